// *** src/dic_pkg.sv ***
// ---------------------------------------------------------------
// How it works
// R1: pin enable bit off leaves pin undriven
// R2: one shared output-enable strobe for DRAM areas
// R3: synchronous DRAM gets clock enable on pin
// R4: timing bit picks row strobe half-state
// R5: timing bit picks two or three column states
// R6: reserved bits stay readable and writable
// R7: three-bit code assigns space; zero all normal
// R8: code one keeps areas three to five normal
// R9: continuous DRAM puts row strobe on select two
// R10: continuous SDRAM strobes on selects two to four
// R11: mode-setting code issues mode register commands
// R12: code one makes area two DRAM
// R13: codes two, three, seven decode; six prohibited
// ---------------------------------------------------------------
package dic_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] DIC_CTRL_OFS = 8'h00;
   localparam logic [7:0] DIC_STAT_OFS = 8'h04;
   localparam logic [7:0] DIC_CTRL_RESET = 8'h00;
   // bit positions inside the stored upper byte, and that byte's lowest bit in the bus word
   localparam int DIC_PEN_POS = 7;
   localparam int DIC_RTIM_POS = 6;
   localparam int DIC_RSV13_POS = 5;
   localparam int DIC_CLEN_POS = 4;
   localparam int DIC_RSV11_POS = 3;
   localparam int DIC_SEL_LSB = 0;
   localparam int DIC_CTRL_LSB = 8;

   // ---------------------------------------------------------------
   // space select codes
   // ---------------------------------------------------------------
   localparam logic [2:0] DIC_SEL_NORMAL = 3'h0;
   localparam logic [2:0] DIC_SEL_DRAM2 = 3'h1;
   localparam logic [2:0] DIC_SEL_DRAM23 = 3'h2;
   localparam logic [2:0] DIC_SEL_DRAM25 = 3'h3;
   localparam logic [2:0] DIC_SEL_SDRAM = 3'h4;
   localparam logic [2:0] DIC_SEL_MODESET = 3'h5;
   localparam logic [2:0] DIC_SEL_PROHIB = 3'h6;
   localparam logic [2:0] DIC_SEL_CONT = 3'h7;

   // ---------------------------------------------------------------
   // timing counts, in states of two clock halves each
   // ---------------------------------------------------------------
   localparam logic [1:0] DIC_COL_SHORT = 2'h2;
   localparam logic [1:0] DIC_COL_LONG = 2'h3;

   typedef enum logic [1:0] {
      DIC_IDLE = 2'b00,
      DIC_ROW = 2'b01,
      DIC_COL = 2'b11,
      DIC_END = 2'b10
   } dic_state_t;

endpackage : dic_pkg

// *** src/dic_cfg_if.sv ***
`timescale 1ns/10ps
interface dic_cfg_if;
   logic row_early;
   logic col_long;
   logic pin_en;
   logic [3:0] dram_area;
   logic cont_dram;
   logic cont_sdram;
   logic mode_set;
   logic prohibited;
   modport src (output row_early, col_long, pin_en, dram_area, cont_dram,
                cont_sdram, mode_set, prohibited);
   modport dst (input row_early, col_long, pin_en, dram_area, cont_dram,
                cont_sdram, mode_set, prohibited);
endinterface : dic_cfg_if

// *** src/dic_space_decode.sv ***
`timescale 1ns/10ps
module dic_space_decode (
   input wire logic [7:0] ctrl,
   dic_cfg_if.src cfg
);
   // ---------------------------------------------------------------
   // per-area DRAM flags, index 0 is area 2
   // ---------------------------------------------------------------
   function automatic logic [3:0] dic_dram_areas(input logic [2:0] sel);
      case (sel)
         dic_pkg::DIC_SEL_DRAM2: dic_dram_areas = 4'h1; // R12 R8
         dic_pkg::DIC_SEL_DRAM23: dic_dram_areas = 4'h3; // R13
         dic_pkg::DIC_SEL_DRAM25: dic_dram_areas = 4'hF; // R13
         dic_pkg::DIC_SEL_CONT: dic_dram_areas = 4'hF; // R13
         default: dic_dram_areas = 4'h0; // R7
      endcase
   endfunction : dic_dram_areas

   logic [2:0] sel;
   assign sel = ctrl[dic_pkg::DIC_SEL_LSB +: 3];
   assign cfg.row_early = ctrl[dic_pkg::DIC_RTIM_POS];
   assign cfg.col_long = ctrl[dic_pkg::DIC_CLEN_POS];
   assign cfg.pin_en = ctrl[dic_pkg::DIC_PEN_POS];
   assign cfg.dram_area = dic_dram_areas(sel); // R7
   assign cfg.cont_dram = (sel == dic_pkg::DIC_SEL_CONT); // R13
   assign cfg.cont_sdram = (sel == dic_pkg::DIC_SEL_SDRAM); // R10
   assign cfg.mode_set = (sel == dic_pkg::DIC_SEL_MODESET); // R11
   // prohibited code falls back to normal space
   assign cfg.prohibited = (sel == dic_pkg::DIC_SEL_PROHIB); // R13
endmodule : dic_space_decode

// *** src/dic_strobe_seq.sv ***
`timescale 1ns/10ps
module dic_strobe_seq (
   input wire logic clk,
   input wire logic rst_n,
   dic_cfg_if.dst cfg,
   input wire logic acc_req,
   input wire logic [1:0] acc_area,
   input wire logic acc_write,
   output logic acc_busy,
   output logic acc_done,
   output logic [3:0] cs_n,
   output logic cas_n,
   output logic we_n,
   output logic oe_pin,
   output logic oe_pin_oe
);
   dic_pkg::dic_state_t state_reg;
   logic half_reg;
   logic [1:0] cnt_reg;
   logic [1:0] area_reg;
   logic wr_reg, dram_reg, cont_reg, sd_reg, mrs_reg;
   logic go, ras_act, cas_act, oe_act, sd_ras, sd_cas, sd_we, active;
   logic [1:0] col_len;
   logic [3:0] cs_next;

   assign go = acc_req && (state_reg == dic_pkg::DIC_IDLE);
   assign col_len = cfg.col_long ? dic_pkg::DIC_COL_LONG
                             : dic_pkg::DIC_COL_SHORT; // R5

   // ---------------------------------------------------------------
   // state sequence: one row state, then the column states
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= dic_pkg::DIC_IDLE;
         half_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         case (state_reg)
            dic_pkg::DIC_IDLE: begin
               half_reg <= 1'b0;
               cnt_reg <= 2'h0;
               if (go) begin
                  state_reg <= dic_pkg::DIC_ROW;
               end
            end
            dic_pkg::DIC_ROW: begin
               half_reg <= ~half_reg;
               if (half_reg) begin
                  state_reg <= dic_pkg::DIC_COL;
               end
            end
            dic_pkg::DIC_COL: begin
               half_reg <= ~half_reg;
               if (half_reg) begin
                  if (cnt_reg == col_len - 2'h1) begin // R5
                     state_reg <= dic_pkg::DIC_END;
                  end else begin
                     cnt_reg <= cnt_reg + 2'h1;
                  end
               end
            end
            default: begin
               state_reg <= dic_pkg::DIC_IDLE;
            end
         endcase
      end
   end

   // the access kind is frozen at acceptance, but the timing bits and the oe_pin source stay live,
   // so a register write in mid-access can still change the strobe pattern
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         area_reg <= 2'h0;
         wr_reg <= 1'b0;
         dram_reg <= 1'b0;
         cont_reg <= 1'b0;
         sd_reg <= 1'b0;
         mrs_reg <= 1'b0;
      end else if (go) begin
         area_reg <= acc_area;
         wr_reg <= acc_write;
         dram_reg <= cfg.dram_area[acc_area]; // R7
         cont_reg <= cfg.cont_dram; // R9
         sd_reg <= cfg.cont_sdram || cfg.mode_set; // R10
         mrs_reg <= cfg.mode_set; // R11
      end
   end

   // ---------------------------------------------------------------
   // strobe terms
   // ---------------------------------------------------------------
   always_comb begin
      active = (state_reg == dic_pkg::DIC_ROW) ||
               (state_reg == dic_pkg::DIC_COL);
      ras_act = ((state_reg == dic_pkg::DIC_ROW) &&
                 (half_reg || cfg.row_early)) || // R4
                (state_reg == dic_pkg::DIC_COL);
      cas_act = (state_reg == dic_pkg::DIC_COL) &&
                (half_reg || cnt_reg != 2'h0);
      oe_act = dram_reg && !wr_reg && (state_reg == dic_pkg::DIC_COL);
      sd_ras = (state_reg == dic_pkg::DIC_ROW);
      sd_cas = (mrs_reg && sd_ras) ||
               ((state_reg == dic_pkg::DIC_COL) && cnt_reg == 2'h0);
      sd_we = (mrs_reg && sd_ras) ||
              (wr_reg && (state_reg == dic_pkg::DIC_COL) &&
               cnt_reg == 2'h0);
      cs_next = 4'hF;
      if (sd_reg) begin
         cs_next[0] = ~sd_ras; // R10 R11
         cs_next[1] = ~sd_cas; // R10 R11
         cs_next[2] = ~sd_we; // R10 R11
      end else if (cont_reg) begin
         cs_next[0] = ~ras_act; // R9
      end else begin
         cs_next[area_reg] = dram_reg ? ~ras_act : ~active; // R12 R8
      end
   end

   // ---------------------------------------------------------------
   // registered pins
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_n <= 4'hF;
         cas_n <= 1'b1;
         we_n <= 1'b1;
         oe_pin <= 1'b1;
         oe_pin_oe <= 1'b0;
      end else begin
         cs_n <= cs_next;
         cas_n <= ~(dram_reg && cas_act);
         we_n <= ~(dram_reg && wr_reg && state_reg == dic_pkg::DIC_COL);
         oe_pin_oe <= cfg.pin_en; // R1
         // clock enable stays high for synchronous DRAM
         oe_pin <= (cfg.cont_sdram || cfg.mode_set) ? 1'b1 // R3
                                                    : ~oe_act; // R2
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_busy <= 1'b0;
         acc_done <= 1'b0;
      end else begin
         acc_busy <= go || (acc_busy && state_reg != dic_pkg::DIC_END);
         acc_done <= (state_reg == dic_pkg::DIC_END);
      end
   end
endmodule : dic_strobe_seq

// *** src/dic_top.sv ***
`timescale 1ns/10ps
module dic_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic acc_req,
   input wire logic [1:0] acc_area,
   input wire logic acc_write,
   output logic acc_busy,
   output logic acc_done,
   output logic [3:0] cs_n,
   output logic cas_n,
   output logic we_n,
   output logic oe_pin,
   output logic oe_pin_oe
);
   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [7:0] ctrl_reg;
   logic dp_valid_reg;
   logic dp_write_reg;
   logic [7:0] dp_addr_reg;
   logic ap;
   logic wr_ctrl;
   logic [7:0] ctrl_view;
   logic [31:0] rd_next;

   dic_cfg_if cfg_bus ();

   dic_space_decode u_decode (
      .ctrl(ctrl_reg),
      .cfg(cfg_bus.src)
   );

   dic_strobe_seq u_seq (
      .clk(hclk),
      .rst_n(hresetn),
      .cfg(cfg_bus.dst),
      .acc_req(acc_req),
      .acc_area(acc_area),
      .acc_write(acc_write),
      .acc_busy(acc_busy),
      .acc_done(acc_done),
      .cs_n(cs_n),
      .cas_n(cas_n),
      .we_n(we_n),
      .oe_pin(oe_pin),
      .oe_pin_oe(oe_pin_oe)
   );

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   // hsize is not checked: only whole-word transfers are expected
   assign ap = hsel && htrans[1] && hready;
   assign wr_ctrl = dp_valid_reg && dp_write_reg &&
                    (dp_addr_reg == dic_pkg::DIC_CTRL_OFS);
   // forwarding keeps a read right behind a write from going stale
   assign ctrl_view = wr_ctrl ? hwdata[dic_pkg::DIC_CTRL_LSB +: 8]
                              : ctrl_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
      end else begin
         dp_valid_reg <= ap;
         if (ap) begin
            dp_write_reg <= hwrite;
            dp_addr_reg <= {haddr[7:2], 2'b00};
         end
      end
   end

   // upper byte only; lower byte fields are not implemented
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= dic_pkg::DIC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= hwdata[dic_pkg::DIC_CTRL_LSB +: 8]; // R6
      end
   end

   always_comb begin
      rd_next = 32'h0000_0000;
      if (haddr[7:0] == dic_pkg::DIC_CTRL_OFS) begin
         rd_next[dic_pkg::DIC_CTRL_LSB +: 8] = ctrl_view; // R6
      end else if (haddr[7:0] == dic_pkg::DIC_STAT_OFS) begin
         rd_next[10:0] = {cfg_bus.prohibited, cfg_bus.mode_set,
                          cfg_bus.cont_sdram, cfg_bus.cont_dram,
                          cfg_bus.dram_area, acc_done, acc_busy,
                          oe_pin_oe};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (ap && !hwrite) begin
            hrdata <= rd_next;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic go;
   logic [2:0] sel;
   assign go = acc_req && !acc_busy;
   assign sel = ctrl_reg[dic_pkg::DIC_SEL_LSB +: 3];

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   pin_release_a: assert property ( // R1
      !ctrl_reg[dic_pkg::DIC_PEN_POS] |=> !oe_pin_oe)
      else $error("strobe pin driven while disabled");

   oe_shared_a: assert property ( // R2
      oe_pin_oe && !oe_pin |-> acc_busy && we_n && cs_n != 4'hF)
      else $error("output-enable strobe outside a DRAM read");

   cke_high_a: assert property ( // R3
      ctrl_reg[dic_pkg::DIC_PEN_POS] && sel == dic_pkg::DIC_SEL_SDRAM
      ##1 ctrl_reg[dic_pkg::DIC_PEN_POS] |-> oe_pin_oe && oe_pin)
      else $error("clock enable not driven high");

   ras_early_a: assert property ( // R4
      go && sel == dic_pkg::DIC_SEL_CONT && ctrl_reg[dic_pkg::DIC_RTIM_POS]
      |-> ##2 !cs_n[0])
      else $error("row strobe not at row state start");

   ras_late_a: assert property ( // R4
      go && sel == dic_pkg::DIC_SEL_CONT && !ctrl_reg[dic_pkg::DIC_RTIM_POS]
      |-> ##2 cs_n[0] ##1 !cs_n[0])
      else $error("row strobe not at row state middle");

   col_short_a: assert property ( // R5
      $fell(cas_n) && !ctrl_reg[dic_pkg::DIC_CLEN_POS]
      |-> !cas_n[*3] ##1 cas_n)
      else $error("two-state column cycle wrong length");

   col_long_a: assert property ( // R5
      $fell(cas_n) && ctrl_reg[dic_pkg::DIC_CLEN_POS]
      |-> !cas_n[*5] ##1 cas_n)
      else $error("three-state column cycle wrong length");

   rsv_kept_a: assert property ( // R6
      wr_ctrl |=> ctrl_reg[dic_pkg::DIC_RSV13_POS] ==
         $past(hwdata[dic_pkg::DIC_CTRL_LSB + dic_pkg::DIC_RSV13_POS]) &&
         ctrl_reg[dic_pkg::DIC_RSV11_POS] ==
         $past(hwdata[dic_pkg::DIC_CTRL_LSB + dic_pkg::DIC_RSV11_POS]))
      else $error("reserved bit not stored");

   normal_space_a: assert property ( // R7
      go && sel == dic_pkg::DIC_SEL_NORMAL && acc_area == 2'h2
      |-> ##2 !cs_n[2] ##[1:8] acc_done && cas_n)
      else $error("normal space access wrong");

   area3_normal_a: assert property ( // R8
      go && sel == dic_pkg::DIC_SEL_DRAM2 && acc_area == 2'h1
      |-> ##2 !cs_n[1] && cas_n ##2 cas_n)
      else $error("area three not normal");

   area2_dram_a: assert property ( // R12
      go && sel == dic_pkg::DIC_SEL_DRAM2 && acc_area == 2'h0
      |-> ##4 !cs_n[0] ##[1:3] !cas_n)
      else $error("area two not DRAM");

   cont_dram_a: assert property ( // R9
      go && sel == dic_pkg::DIC_SEL_CONT && acc_area == 2'h3
      |-> ##3 !cs_n[0] && cs_n[3])
      else $error("row strobe not on select two");

   sdram_pins_a: assert property ( // R10
      go && sel == dic_pkg::DIC_SEL_SDRAM
      |-> ##2 (!cs_n[0] && cs_n[1]) ##2 (cs_n[0] && !cs_n[1]))
      else $error("synchronous DRAM strobes misplaced");

   mode_cmd_a: assert property ( // R11
      go && sel == dic_pkg::DIC_SEL_MODESET |-> ##2 cs_n[2:0] == 3'h0)
      else $error("mode register command missing");

   area5_dram_a: assert property ( // R13
      go && sel == dic_pkg::DIC_SEL_DRAM25 && acc_area == 2'h3 &&
      ctrl_reg[dic_pkg::DIC_RTIM_POS] |-> ##2 !cs_n[3])
      else $error("area five not DRAM");

   prohib_normal_a: assert property ( // R13
      go && sel == dic_pkg::DIC_SEL_PROHIB |-> ##3 cas_n ##2 cas_n)
      else $error("prohibited code acted as DRAM");
endmodule : dic_top

// *** testbench/dic_dram_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// passive memory side, tallies pin activity
// ----------------------------------------
module dic_dram_model (
   input wire logic clk,
   input wire logic clr,
   input wire logic [3:0] cs_n,
   input wire logic cas_n,
   input wire logic oe_pin,
   input wire logic oe_pin_oe,
   input wire logic we_n,
   output logic [3:0] cs_seen,
   output logic [7:0] cas_cnt,
   output logic [7:0] ras_cnt,
   output logic [7:0] we_cnt,
   output logic oe_low,
   output logic cmd_seen
);
   // an undriven pin never counts as an asserted strobe
   always_ff @(posedge clk) begin
      if (clr) begin
         cs_seen <= 4'h0;
         cas_cnt <= 8'h00;
         ras_cnt <= 8'h00;
         we_cnt <= 8'h00;
         oe_low <= 1'b0;
         cmd_seen <= 1'b0;
      end else begin
         cs_seen <= cs_seen | ~cs_n;
         cas_cnt <= cas_cnt + {7'h00, ~cas_n};
         ras_cnt <= ras_cnt + {7'h00, ~cs_n[0]};
         we_cnt <= we_cnt + {7'h00, ~we_n};
         oe_low <= oe_low | (oe_pin_oe & ~oe_pin);
         cmd_seen <= cmd_seen | (cs_n[2:0] == 3'h0);
      end
   end
endmodule : dic_dram_model

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// bench
// ----------------------------------------
module testbench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic acc_req = 1'b0;
   logic [1:0] acc_area = 2'h0;
   logic acc_write = 1'b0;
   logic acc_busy;
   logic acc_done;
   logic [3:0] cs_n;
   logic cas_n;
   logic we_n;
   logic oe_pin;
   logic oe_pin_oe;
   logic clr = 1'b0;
   logic [3:0] cs_seen;
   logic [7:0] cas_cnt;
   logic [7:0] ras_cnt;
   logic oe_low;
   logic cmd_seen;
   logic [7:0] we_cnt;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [31:0] d;
   logic [3:0] exp_flag [0:7] = '{4'h0, 4'h0, 4'h0, 4'h0,
                                  4'h2, 4'h4, 4'h8, 4'h1};
   logic [3:0] exp_area [0:7] = '{4'h0, 4'h1, 4'h3, 4'hF,
                                  4'h0, 4'h0, 4'h0, 4'hF};

   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;

   dic_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .acc_req(acc_req),
      .acc_area(acc_area), .acc_write(acc_write), .acc_busy(acc_busy),
      .acc_done(acc_done), .cs_n(cs_n), .cas_n(cas_n), .we_n(we_n),
      .oe_pin(oe_pin), .oe_pin_oe(oe_pin_oe));

   dic_dram_model i_mem (.clk(hclk), .clr(clr), .cs_n(cs_n),
      .cas_n(cas_n), .oe_pin(oe_pin), .oe_pin_oe(oe_pin_oe),
      .cs_seen(cs_seen), .cas_cnt(cas_cnt), .ras_cnt(ras_cnt),
      .oe_low(oe_low), .cmd_seen(cmd_seen), .we_n(we_n),
      .we_cnt(we_cnt));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic close_out;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one single word transfer; no wait count is assumed
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : xfer

   task automatic cfg(input logic [7:0] v);
      logic [31:0] r;
      xfer(1'b1, 8'h00, {16'h0000, v, 8'h00}, r);
      // live settings reach the pin flops one edge after the store
      repeat (2) @(posedge hclk);
   endtask : cfg

   // request is accepted at the first edge since the port is idle
   task automatic acc(input logic [1:0] ar, input logic w);
      clr <= 1'b1;
      acc_req <= 1'b1;
      acc_area <= ar;
      acc_write <= w;
      @(posedge hclk);
      clr <= 1'b0;
      acc_req <= 1'b0;
      @(posedge hclk);
      chk("access busy", 32'h1, {31'h0, acc_busy});
      while (acc_done !== 1'b1) @(posedge hclk);
      @(posedge hclk);
   endtask : acc

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      xfer(1'b0, 8'h00, 32'h0, d);
      chk("ctrl reset", 32'h00000000, d);
      chk("okay response", 32'h0, {31'h0, hresp});
      chk("pin drive at reset", 32'h0, {31'h0, oe_pin_oe});
      xfer(1'b1, 8'h00, 32'hFFFFFFFF, d);
      xfer(1'b0, 8'h00, 32'h0, d);
      chk("ctrl all ones", 32'h0000FF00, d);
      xfer(1'b1, 8'h08, 32'hFFFFFFFF, d);
      xfer(1'b0, 8'h08, 32'h0, d);
      chk("unmapped", 32'h00000000, d);
      cfg(8'h00);
      chk("pin drive off", 32'h0, {31'h0, oe_pin_oe});
   endtask : t_regs

   task automatic t_decode;
      for (int c = 0; c < 8; c++) begin
         cfg({5'h00, c[2:0]});
         xfer(1'b0, 8'h04, 32'h0, d);
         chk("space flags", {28'h0, exp_flag[c]}, {28'h0, d[10:7]});
         chk("dram areas", {28'h0, exp_area[c]}, {28'h0, d[6:3]});
      end
   endtask : t_decode

   task automatic t_timing;
      logic [7:0] r0;
      for (int k = 0; k < 2; k++) begin
         cfg({3'h0, k[0], 4'h1});
         acc(2'h0, 1'b0);
         chk("column cycles", 32'(2 * (2 + k) - 1), {24'h0, cas_cnt});
         r0 = ras_cnt;
         cfg({3'h2, k[0], 4'h1});
         acc(2'h0, 1'b0);
         chk("row lead", {24'h0, r0 + 8'h01}, {24'h0, ras_cnt});
      end
   endtask : t_timing

   task automatic t_areas;
      cfg(8'h01);
      acc(2'h1, 1'b0);
      chk("area three normal cas", 32'h0, {24'h0, cas_cnt});
      chk("area three select", 32'h2, {28'h0, cs_seen});
      acc(2'h0, 1'b1);
      chk("area two dram", 32'h1, {31'h0, cas_cnt != 8'h00});
      chk("dram write strobe", 32'h4, {24'h0, we_cnt});
      cfg(8'h07);
      acc(2'h3, 1'b0);
      chk("continuous row pin", 32'h1, {28'h0, cs_seen});
      cfg(8'h47);
      acc(2'h2, 1'b0);
      chk("continuous early row", 32'h6, {24'h0, ras_cnt});
      cfg(8'h00);
      acc(2'h2, 1'b0);
      chk("normal select", 32'h4, {28'h0, cs_seen});
      chk("normal no column", 32'h0, {24'h0, cas_cnt});
      cfg(8'h43);
      acc(2'h3, 1'b0);
      chk("area five dram", 32'h3, {24'h0, cas_cnt});
      chk("area five select", 32'h8, {28'h0, cs_seen});
      cfg(8'h06);
      acc(2'h0, 1'b0);
      chk("prohibited normal", 32'h0, {24'h0, cas_cnt});
      chk("prohibited select", 32'h1, {28'h0, cs_seen});
   endtask : t_areas

   task automatic t_strobes;
      cfg(8'h81);
      chk("pin driven", 32'h1, {31'h0, oe_pin_oe});
      acc(2'h0, 1'b0);
      chk("shared oe read", 32'h1, {31'h0, oe_low});
      cfg(8'h84);
      acc(2'h0, 1'b1);
      chk("sdram write pins", 32'h7, {29'h0, cs_seen[2:0]});
      chk("clock enable kept", 32'h0, {31'h0, oe_low});
      acc(2'h0, 1'b0);
      chk("sdram read pins", 32'h3, {29'h0, cs_seen[2:0]});
      cfg(8'h05);
      acc(2'h0, 1'b1);
      chk("mode command", 32'h1, {31'h0, cmd_seen});
   endtask : t_strobes

   // ----------------------------------------
   // run and watchdog
   // ----------------------------------------
   // each step takes well under two hundred cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         close_out();
      end
   end

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_decode();
      t_timing();
      t_areas();
      t_strobes();
      close_out();
   end
endmodule : testbench
